// *** src/rtc_top.sv ***
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Operation
// - counter clock is main or low-power oscillator, not the gated cpu clock
// - keeps counting in idle or power down when enabled for it
// - interrupt every tick and after every n+1 ticks for programmed n, when enabled
// - divider stages plus time counter form a 58-bit timer
// - with wake config set, leaves power down after programmed delay
// - a fixed divide-by-64 stage feeds the 20-bit divider
// - divider reloads from the period register each tick
// - the period register sets the tick period
// - tick interrupt request may be raised once per tick period
// - software-writable 32-bit time counter advances on each tick
// - time counter is compared continuously with the alarm register
// - equality of time and alarm raises the alarm request
// - n-tick and alarm requests routable to a wake-capable external interrupt
// - oscillator-off bit stops the oscillator on entry to power down
// - timer disabled and power down stops both oscillators
// - low-power oscillation found at reset selects it; main osc off in power down
// - otherwise main osc drives counter and stays on in power down unless disabled
// - registers are reached over the peripheral bus
module rtc_top #(
   parameter int TIME_W = 32
) (
   input  wire logic        REF_CLK_I,
   input  wire logic        RST_I,
   input  wire logic        LP_OSC_PRESENT_I,
   input  wire logic        IDLE_I,
   input  wire logic        POWERDOWN_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   output logic             IRQ_O,
   output logic             EXT_IRQ_O,
   output logic             WAKE_O,
   output logic             MAIN_OSC_EN_O,
   output logic             LP_OSC_EN_O,
   output logic             SRC_LP_O
);
   rtc_tick_if tk ();

   logic [rtc_pkg::CTRL_W-1:0] ctrl;
   logic [rtc_pkg::DIV_W-1:0]  period;
   logic [TIME_W-1:0]          time_cnt;
   logic [TIME_W-1:0]          alarm;
   logic [31:0]                ntick;
   logic [31:0]                ntick_cnt;
   logic [rtc_pkg::ST_W-1:0]   status;
   logic [rtc_pkg::ST_W-1:0]   mask;
   logic [1:0]                 route;
   logic                       src_lp;
   logic                       src_caught;
   logic                       alarm_eq_q;
   logic                       wr;
   logic                       rd;
   logic                       hit;
   logic [31:0]                rd_data;
   logic                       run;
   logic                       ev_tick;
   logic                       ev_ntick;
   logic                       ev_alarm;
   logic                       alarm_eq;
   logic [rtc_pkg::ST_W-1:0]   ev;
   logic [rtc_pkg::ST_W-1:0]   next_status;

   // bus access; pready answers in the access cycle itself
   assign wr = PSEL_I && PENABLE_I && PWRITE_I;
   assign rd = PSEL_I && PENABLE_I && !PWRITE_I;

   // the counter runs off the selected oscillator; power modes gate it
   always_comb begin
      run = ctrl[rtc_pkg::CTRL_EN];
      if (POWERDOWN_I) begin
         run = run && ctrl[rtc_pkg::CTRL_RUN_PD] && !ctrl[rtc_pkg::CTRL_OSC_OFF];
      end else if (IDLE_I) begin
         run = run && ctrl[rtc_pkg::CTRL_RUN_IDLE];
      end
   end

   assign tk.run    = run;
   assign tk.period = period;

   rtc_prescaler u_pre (
      .clk_i (REF_CLK_I),
      .rst_i (RST_I),
      .tk    (tk)
   );

   assign alarm_eq = (time_cnt == alarm);
   assign ev_tick  = tk.tick;
   assign ev_ntick = tk.tick && (ntick_cnt == ntick);
   assign ev_alarm = alarm_eq && !alarm_eq_q;
   assign ev = {ev_alarm, ev_ntick, ev_tick};

   // source choice caught once after the reset release
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         src_lp     <= 1'b0;
         src_caught <= 1'b0;
      end else if (!src_caught) begin
         src_lp     <= LP_OSC_PRESENT_I;
         src_caught <= 1'b1;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         ctrl   <= rtc_pkg::CTRL_RST;
         period <= rtc_pkg::PERIOD_RST;
         ntick  <= rtc_pkg::NTICK_RST;
         mask   <= rtc_pkg::ST_ZERO;
         route  <= rtc_pkg::ROUTE_RST;
      end else if (wr) begin
         if (PADDR_I == rtc_pkg::OFF_CTRL) begin
            ctrl <= PWDATA_I[rtc_pkg::CTRL_W-1:0];
         end else if (PADDR_I == rtc_pkg::OFF_PERIOD) begin
            period <= PWDATA_I[rtc_pkg::DIV_W-1:0];
         end else if (PADDR_I == rtc_pkg::OFF_NTICK) begin
            ntick <= PWDATA_I;
         end else if (PADDR_I == rtc_pkg::OFF_MASK) begin
            mask <= PWDATA_I[rtc_pkg::ST_W-1:0];
         end else if (PADDR_I == rtc_pkg::OFF_ROUTE) begin
            route <= PWDATA_I[1:0];
         end
      end
   end

   // time counter: software write sets the time, tick advances it
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         time_cnt <= TIME_W'(0);
      end else if (wr && PADDR_I == rtc_pkg::OFF_TIME) begin
         time_cnt <= PWDATA_I[TIME_W-1:0];
      end else if (tk.tick) begin
         time_cnt <= time_cnt + TIME_W'(1);
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         alarm <= rtc_pkg::ALARM_RST[TIME_W-1:0];
      end else if (wr && PADDR_I == rtc_pkg::OFF_ALARM) begin
         alarm <= PWDATA_I[TIME_W-1:0];
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         alarm_eq_q <= 1'b0;
      end else begin
         alarm_eq_q <= alarm_eq;
      end
   end

   // n-tick counter restarts on match or when n is rewritten
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         ntick_cnt <= rtc_pkg::WORD_ZERO;
      end else if (wr && PADDR_I == rtc_pkg::OFF_NTICK) begin
         ntick_cnt <= rtc_pkg::WORD_ZERO;
      end else if (ev_ntick) begin
         ntick_cnt <= rtc_pkg::WORD_ZERO;
      end else if (tk.tick) begin
         ntick_cnt <= ntick_cnt + rtc_pkg::WORD_ONE;
      end
   end

   // sticky status, write one to clear, a new event wins over the clear
   always_comb begin
      next_status = status;
      if (wr && PADDR_I == rtc_pkg::OFF_STATUS) begin
         next_status = status & ~PWDATA_I[rtc_pkg::ST_W-1:0];
      end
      next_status = next_status | ev;
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         status <= rtc_pkg::ST_ZERO;
      end else begin
         status <= next_status;
      end
   end

   always_comb begin
      hit     = 1'b1;
      rd_data = rtc_pkg::WORD_ZERO;
      if (PADDR_I == rtc_pkg::OFF_CTRL) begin
         rd_data[rtc_pkg::CTRL_W-1:0] = ctrl;
         rd_data[rtc_pkg::CTRL_SRC_LP] = src_lp;
      end else if (PADDR_I == rtc_pkg::OFF_PERIOD) begin
         rd_data[rtc_pkg::DIV_W-1:0] = period;
      end else if (PADDR_I == rtc_pkg::OFF_DIVCNT) begin
         rd_data[rtc_pkg::DIV_W-1:0] = tk.div_cnt;
      end else if (PADDR_I == rtc_pkg::OFF_TIME) begin
         rd_data[TIME_W-1:0] = time_cnt;
      end else if (PADDR_I == rtc_pkg::OFF_ALARM) begin
         rd_data[TIME_W-1:0] = alarm;
      end else if (PADDR_I == rtc_pkg::OFF_NTICK) begin
         rd_data = ntick;
      end else if (PADDR_I == rtc_pkg::OFF_STATUS) begin
         rd_data[rtc_pkg::ST_W-1:0] = status;
      end else if (PADDR_I == rtc_pkg::OFF_MASK) begin
         rd_data[rtc_pkg::ST_W-1:0] = mask;
      end else if (PADDR_I == rtc_pkg::OFF_ROUTE) begin
         rd_data[1:0] = route;
      end else if (PADDR_I == rtc_pkg::OFF_PRECNT) begin
         rd_data[rtc_pkg::PRE_W-1:0] = tk.pre_cnt;
      end else begin
         hit = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         PRDATA_O  <= rtc_pkg::WORD_ZERO;
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
      end else begin
         PREADY_O  <= PSEL_I && !PENABLE_I;
         PSLVERR_O <= PSEL_I && !PENABLE_I && !hit;
         if (PSEL_I && !PENABLE_I) begin
            PRDATA_O <= rd_data;
         end
      end
   end

   // outputs
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         IRQ_O         <= 1'b0;
         EXT_IRQ_O     <= 1'b0;
         WAKE_O        <= 1'b0;
         MAIN_OSC_EN_O <= 1'b1;
         LP_OSC_EN_O   <= 1'b1;
         SRC_LP_O      <= 1'b0;
      end else begin
         IRQ_O     <= |(next_status & mask);
         EXT_IRQ_O <= |(next_status[rtc_pkg::ST_ALARM:rtc_pkg::ST_NTICK] & route);
         WAKE_O    <= POWERDOWN_I && ctrl[rtc_pkg::CTRL_WAKE_CFG]
                      && |(next_status[rtc_pkg::ST_ALARM:rtc_pkg::ST_NTICK] & route);
         SRC_LP_O  <= src_lp;
         if (POWERDOWN_I) begin
            if (!ctrl[rtc_pkg::CTRL_EN]) begin
               MAIN_OSC_EN_O <= 1'b0;
               LP_OSC_EN_O   <= 1'b0;
            end else if (src_lp) begin
               MAIN_OSC_EN_O <= 1'b0;
               LP_OSC_EN_O   <= !ctrl[rtc_pkg::CTRL_OSC_OFF];
            end else begin
               MAIN_OSC_EN_O <= !ctrl[rtc_pkg::CTRL_OSC_OFF];
               LP_OSC_EN_O   <= 1'b0;
            end
         end else begin
            MAIN_OSC_EN_O <= 1'b1;
            LP_OSC_EN_O   <= 1'b1;
         end
      end
   end
endmodule : rtc_top

// *** src/rtc_pkg.sv ***
package rtc_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 12;
   localparam int DIV_W = 20;
   localparam int PRE_W = 6;
   localparam int TIME_W = 32;
   localparam logic [5:0] PRE_LAST = 6'h3f;
   // register byte offsets
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_PERIOD = 12'h004;
   localparam logic [11:0] OFF_DIVCNT = 12'h008;
   localparam logic [11:0] OFF_TIME = 12'h00c;
   localparam logic [11:0] OFF_ALARM = 12'h010;
   localparam logic [11:0] OFF_NTICK = 12'h014;
   localparam logic [11:0] OFF_STATUS = 12'h018;
   localparam logic [11:0] OFF_MASK = 12'h01c;
   localparam logic [11:0] OFF_ROUTE = 12'h020;
   localparam logic [11:0] OFF_PRECNT = 12'h024;
   // control register fields
   localparam int CTRL_EN = 0;
   localparam int CTRL_RUN_IDLE = 1;
   localparam int CTRL_RUN_PD = 2;
   localparam int CTRL_OSC_OFF = 3;
   localparam int CTRL_WAKE_CFG = 4;
   localparam int CTRL_SRC_LP = 5;
   localparam int CTRL_W = 6;
   // status / mask fields
   localparam int ST_TICK = 0;
   localparam int ST_NTICK = 1;
   localparam int ST_ALARM = 2;
   localparam int ST_W = 3;
   localparam logic [5:0] CTRL_RST = 6'h01;
   localparam logic [19:0] PERIOD_RST = 20'h00000;
   localparam logic [31:0] NTICK_RST = 32'h00000000;
   localparam logic [31:0] ALARM_RST = 32'hffffffff;
   localparam logic [31:0] WORD_ZERO = 32'h00000000;
   localparam logic [31:0] WORD_ONE = 32'h00000001;
   localparam logic [19:0] DIV_ZERO = 20'h00000;
   localparam logic [5:0] PRE_ZERO = 6'h00;
   localparam logic [2:0] ST_ZERO = 3'h0;
   localparam logic [1:0] ROUTE_RST = 2'h0;
endpackage : rtc_pkg

// *** src/rtc_tick_if.sv ***
`timescale 1ns/1ps
interface rtc_tick_if;
   logic        run;
   logic        tick;
   logic [19:0] period;
   logic [19:0] div_cnt;
   logic [5:0]  pre_cnt;
   modport prod (input run, input period, output tick, output div_cnt, output pre_cnt);
   modport cons (output run, output period, input tick, input div_cnt, input pre_cnt);
endinterface : rtc_tick_if

// *** src/rtc_prescaler.sv ***
`timescale 1ns/1ps
module rtc_prescaler (
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   rtc_tick_if.prod    tk
);
   logic [rtc_pkg::PRE_W-1:0] pre;
   logic [rtc_pkg::DIV_W-1:0] div;
   logic                      pre_wrap;

   // fixed divide-by-64 ahead of the reloadable divider
   assign pre_wrap = tk.run && (pre == rtc_pkg::PRE_LAST);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre <= rtc_pkg::PRE_ZERO;
      end else if (tk.run) begin
         pre <= pre + 6'h01;
      end
   end

   // down counter; tick when it expires, then reload from the period value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div     <= rtc_pkg::DIV_ZERO;
         tk.tick <= 1'b0;
      end else begin
         tk.tick <= 1'b0;
         if (pre_wrap) begin
            if (div == rtc_pkg::DIV_ZERO) begin
               div     <= tk.period;
               tk.tick <= 1'b1;
            end else begin
               div <= div - 20'h00001;
            end
         end
      end
   end

   assign tk.div_cnt = div;
   assign tk.pre_cnt = pre;
endmodule : rtc_prescaler

// *** testbench/rtc_top_props.sv ***
`timescale 1ns/1ps
module rtc_top_props #(
   parameter int TIME_W = 32
) (
   input wire logic        REF_CLK_I,
   input wire logic        RST_I,
   input wire logic        LP_OSC_PRESENT_I,
   input wire logic        IDLE_I,
   input wire logic        POWERDOWN_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        PREADY_O,
   input wire logic        PSLVERR_O,
   input wire logic        IRQ_O,
   input wire logic        EXT_IRQ_O,
   input wire logic        WAKE_O,
   input wire logic        MAIN_OSC_EN_O,
   input wire logic        LP_OSC_EN_O,
   input wire logic        SRC_LP_O
);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);
   sequence s_setup;
      PSEL_I && !PENABLE_I && (PADDR_I[1:0] == 2'h0);
   endsequence
   sequence s_answer;
      PREADY_O ##1 !PREADY_O;
   endsequence
   a_ready_after_setup: assert property (s_setup |=> s_answer)
      else $error("ready not a single cycle after setup");
   a_err_decode: assert property (s_setup |=> PSLVERR_O == ($past(PADDR_I) > 12'h024))
      else $error("error response does not match address map");
   a_err_with_ready: assert property (PSLVERR_O |-> PREADY_O)
      else $error("error response without ready");
   a_rdata_hold: assert property (!$past(PSEL_I && !PENABLE_I) |-> $stable(PRDATA_O))
      else $error("read data changed outside a transfer");
   a_osc_on_run: assert property (!POWERDOWN_I |=> MAIN_OSC_EN_O && LP_OSC_EN_O)
      else $error("oscillator off outside power down");
   a_osc_cut_pd: assert property (POWERDOWN_I |=> !(MAIN_OSC_EN_O && LP_OSC_EN_O))
      else $error("both oscillators on in power down");
   a_wake_cause: assert property (WAKE_O |-> EXT_IRQ_O && $past(POWERDOWN_I))
      else $error("wake without routed event in power down");
   // source is caught one edge after release and shown one edge later still
   a_src_fixed: assert property (!$past(RST_I) && !$past(RST_I, 2) && !$past(RST_I, 3)
                                 |-> $stable(SRC_LP_O))
      else $error("source select changed after reset");
endmodule : rtc_top_props
bind rtc_top rtc_top_props #(.TIME_W(TIME_W)) chk_u (.*);

// *** testbench/rtc_prescaler_alarm_counter_tb.sv ***
`timescale 1ns/1ps
module rtc_prescaler_alarm_counter_tb;
   logic        ref_clk;
   logic        rst;
   logic        pd;
   logic        idle;
   logic        lp_present;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        ext_irq;
   logic        wake;
   logic        main_en;
   logic        lp_en;
   logic        src_lp;
   logic [31:0] rdata;
   logic        slverr;
   logic [31:0] cyc = 32'h0;
   logic [31:0] t;
   logic [31:0] t0;
   int          errors = 0;
   int          check_count = 0;
   rtc_top dut_u (
      .REF_CLK_I(ref_clk), .RST_I(rst), .LP_OSC_PRESENT_I(lp_present), .IDLE_I(idle),
      .POWERDOWN_I(pd), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .IRQ_O(irq), .EXT_IRQ_O(ext_irq), .WAKE_O(wake),
      .MAIN_OSC_EN_O(main_en), .LP_OSC_EN_O(lp_en), .SRC_LP_O(src_lp)
   );
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) cyc <= cyc + 32'h1;
   task report_and_stop;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   // one transfer; returns just after the edge that follows release
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         report_and_stop;
      end
      rdata = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb
   task wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 2000) begin
         errors++;
         report_and_stop;
      end
   endtask : wait_irq
   // waits for the tick flag, clears it and sees the request drop
   task tick_sync;
      wait_irq;
      t = cyc;
      apb(1'b1, rtc_pkg::OFF_STATUS, 32'h1);
      @(posedge ref_clk);
      check("irq cleared", 32'h0, 32'(irq));
   endtask : tick_sync
   logic [31:0] cv [3] = '{32'h00, 32'h09, 32'h01};
   initial begin
      rst = 1'b1;
      pd = 1'b0;
      idle = 1'b0;
      lp_present = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      apb(1'b0, rtc_pkg::OFF_CTRL, 32'h0);
      check("ctrl reset", 32'h01, rdata);
      apb(1'b0, rtc_pkg::OFF_ALARM, 32'h0);
      check("alarm reset", 32'hffffffff, rdata);
      apb(1'b1, rtc_pkg::OFF_CTRL, 32'h3f);
      apb(1'b0, rtc_pkg::OFF_CTRL, 32'h0);
      check("ctrl source bit", 32'h1f, rdata);
      apb(1'b0, 12'h028, 32'h0);
      check("unmapped err", 32'h1, 32'(slverr));
      check("unmapped data", 32'h0, rdata);
      check("source main", 32'h0, 32'(src_lp));
      $display("test registers done");
      apb(1'b1, rtc_pkg::OFF_CTRL, 32'h01);
      apb(1'b1, rtc_pkg::OFF_PERIOD, 32'h2);
      apb(1'b1, rtc_pkg::OFF_MASK, 32'h1);
      apb(1'b1, rtc_pkg::OFF_STATUS, 32'h7);
      tick_sync;
      t0 = t;
      apb(1'b1, rtc_pkg::OFF_TIME, 32'hffffffff);
      tick_sync;
      check("tick period", 32'd192, t - t0);
      apb(1'b0, rtc_pkg::OFF_TIME, 32'h0);
      check("time wrap", 32'h0, rdata);
      $display("test tick done");
      apb(1'b1, rtc_pkg::OFF_ALARM, 32'h1);
      apb(1'b1, rtc_pkg::OFF_MASK, 32'h4);
      apb(1'b1, rtc_pkg::OFF_ROUTE, 32'h2);
      apb(1'b1, rtc_pkg::OFF_CTRL, 32'h15);
      // the all-ones time matched the reset alarm earlier; drop that stale flag
      apb(1'b1, rtc_pkg::OFF_STATUS, 32'h7);
      pd <= 1'b1;
      wait_irq;
      check("ext irq", 32'h1, 32'(ext_irq));
      check("wake", 32'h1, 32'(wake));
      check("main osc pd", 32'h1, 32'(main_en));
      check("lp osc pd", 32'h0, 32'(lp_en));
      apb(1'b0, rtc_pkg::OFF_STATUS, 32'h0);
      check("alarm status", 32'h4, rdata & 32'h4);
      pd <= 1'b0;
      apb(1'b1, rtc_pkg::OFF_STATUS, 32'h7);
      $display("test alarm done");
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, rtc_pkg::OFF_CTRL, cv[i]);
         pd <= 1'b1;
         repeat (2) @(posedge ref_clk);
         check("main osc", 32'(i == 2), 32'(main_en));
         check("lp osc", 32'h0, 32'(lp_en));
         pd <= 1'b0;
         @(posedge ref_clk);
      end
      $display("test oscillator done");
      // second reset, now with low-power oscillation present
      lp_present <= 1'b1;
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      apb(1'b0, rtc_pkg::OFF_CTRL, 32'h0);
      check("ctrl lp source", 32'h21, rdata);
      check("source lp", 32'h1, 32'(src_lp));
      for (int i = 1; i < 3; i++) begin
         apb(1'b1, rtc_pkg::OFF_CTRL, cv[i]);
         pd <= 1'b1;
         repeat (2) @(posedge ref_clk);
         check("main osc lp src", 32'h0, 32'(main_en));
         check("lp osc lp src", 32'(i == 2), 32'(lp_en));
         pd <= 1'b0;
         @(posedge ref_clk);
      end
      $display("test low-power source done");
      idle <= 1'b1;
      apb(1'b0, rtc_pkg::OFF_PRECNT, 32'h0);
      t0 = rdata;
      apb(1'b0, rtc_pkg::OFF_PRECNT, 32'h0);
      check("idle stopped", t0, rdata);
      apb(1'b1, rtc_pkg::OFF_CTRL, 32'h03);
      apb(1'b0, rtc_pkg::OFF_PRECNT, 32'h0);
      t0 = rdata;
      // two reads are three clocks apart
      apb(1'b0, rtc_pkg::OFF_PRECNT, 32'h0);
      check("idle running", (t0 + 32'h3) & 32'h3f, rdata);
      idle <= 1'b0;
      $display("test idle done");
      apb(1'b1, rtc_pkg::OFF_NTICK, 32'h1);
      apb(1'b1, rtc_pkg::OFF_ROUTE, 32'h1);
      apb(1'b1, rtc_pkg::OFF_MASK, 32'h2);
      apb(1'b1, rtc_pkg::OFF_STATUS, 32'h7);
      wait_irq;
      t0 = cyc;
      apb(1'b1, rtc_pkg::OFF_STATUS, 32'h2);
      wait_irq;
      check("n-tick period", 32'd128, cyc - t0);
      check("ext irq n-tick", 32'h1, 32'(ext_irq));
      $display("test n-tick done");
      report_and_stop;
   end
endmodule : rtc_prescaler_alarm_counter_tb
